//--- periph_irq_pkg.sv
// constants, register map and carrier types for the peripheral interrupt flag block
package periph_irq_pkg;

    // register port, program counter and return stack geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PC_W   = 13;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W   = 3;

    // register offsets on the plain register port
    localparam logic [ADDR_W-1:0] OFS_FLAGS_ONE   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_TWO   = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_ENABLES_ONE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_ENABLES_TWO = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_INT_CONTROL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_OPTION_CTRL = 4'h5;

    // bit positions, first flag and enable register
    localparam int BIT_CONVERSION_DONE = 6;
    localparam int BIT_SERIAL_COLLISION = 5;
    localparam int BIT_SERIAL_PORT     = 4;
    localparam int BIT_TIMER_TWO_MATCH = 1;
    localparam int BIT_TIMER_ONE_ROLL  = 0;
    // bit positions, second flag and enable register
    localparam int BIT_OUTPUT_UNDERVOLT = 7;
    localparam int BIT_OUTPUT_OVERCURRENT = 5;
    localparam int BIT_OUTPUT_OVERVOLT = 4;
    localparam int BIT_INPUT_SUPPLY_LOW = 1;
    // bit positions, interrupt control register
    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_PERIPH_IRQ_ENABLE = 6;

    // implemented bits; the rest read as zero
    localparam logic [DATA_W-1:0] MASK_ONE = 8'h73;
    localparam logic [DATA_W-1:0] MASK_TWO = 8'hB2;

    // reset values and stack pointer step
    localparam logic [DATA_W-1:0] RST_REG = 8'h00;
    localparam logic [PC_W-1:0]   RST_PC  = 13'h0000;
    localparam logic [SP_W-1:0]   RST_SP  = 3'h0;
    localparam logic [SP_W-1:0]   SP_STEP = 3'h1;

    // common memory window: last bytes of each bank map to bank zero
    localparam logic [6:0] COMMON_BASE = 7'h70;
    localparam int         COMMON_SIZE = 16;
    localparam logic [1:0] COMMON_BANK = 2'h0;

    // event strobes from the peripherals, one cycle each unless noted
    typedef struct packed {
        logic conversion_done;
        logic serial_collision;
        logic serial_event;
        logic timer_one_rollover;
        logic output_undervolt;
        logic output_overcurrent;
        logic output_overvolt;
        logic input_supply_low;   // level, not a strobe
    } periph_events_t;

endpackage

//--- peripheral_interrupt_flags.sv
// peripheral interrupt flags, enables, request logic, return stack and common memory map
//
// Behaviour
// [RULE_01] conversion done flag, bit 6 of flags one, set on conversion completion
// [RULE_02] serial collision flag, bit 5 of flags one, set while pending
// [RULE_03] serial port event flag, bit 4 of flags one, set while pending
// [RULE_04] timer two match flag, bit 1, set on count equal period, sticky
// [RULE_05] timer one rollover flag, bit 0, set on rollover, sticky
// [RULE_06] unimplemented bits of both flag registers read as zero
// [RULE_07] flags set regardless of any enable bit
// [RULE_08] software clears stale flags before enabling their interrupt
// [RULE_09] output undervolt flag, bit 7 of flags two, set on fault
// [RULE_10] output overcurrent flag, bit 5 of flags two, set on fault
// [RULE_11] output overvolt flag, bit 4 of flags two, set on fault
// [RULE_12] bit 1 of flags two shows input supply below acceptable level
// [RULE_13] implemented flag bits readable, writable, zero after reset; bit 1 of flags two ignores writes and follows the supply input
// [RULE_14] interrupt entry pushes only the return address onto the stack
// [RULE_15] service software saves working and status registers itself
// [RULE_16] last sixteen memory bytes shared by every bank
// [RULE_17] no peripheral request without peripheral interrupt enable
// [RULE_18] enable bit at flag position gates that flag
// [RULE_19] request when enabled flag set and both global enables set
`timescale 1ns/1ps

module peripheral_interrupt_flags (
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // register port
    input  wire logic [periph_irq_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [periph_irq_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                                 reg_we,
    input  wire logic                                 reg_re,
    output logic      [periph_irq_pkg::DATA_W-1:0]    reg_rdata,
    // peripheral events
    input  wire periph_irq_pkg::periph_events_t       events,
    input  wire logic [7:0]                           timer_two_count,
    input  wire logic [7:0]                           timer_two_period,
    // core side
    input  wire logic                                 irq_take,
    input  wire logic [periph_irq_pkg::PC_W-1:0]      return_pc,
    input  wire logic                                 return_pop,
    output logic                                      irq_req,
    output logic      [periph_irq_pkg::PC_W-1:0]      stack_top,
    // data memory address mapping
    input  wire logic [1:0]                           mem_bank,
    input  wire logic [6:0]                           mem_offset,
    output logic      [8:0]                           mem_phys_addr
);

    // whole module state
    typedef struct packed {
        logic [periph_irq_pkg::DATA_W-1:0]                        flags_one;
        logic [periph_irq_pkg::DATA_W-1:0]                        flags_two;
        logic [periph_irq_pkg::DATA_W-1:0]                        enables_one;
        logic [periph_irq_pkg::DATA_W-1:0]                        enables_two;
        logic [periph_irq_pkg::DATA_W-1:0]                        int_control;
        logic [periph_irq_pkg::DATA_W-1:0]                        option_ctrl;
        logic [periph_irq_pkg::DATA_W-1:0]                        rdata;
        logic                                                     irq;
        logic                                                     match_prev;
        logic [periph_irq_pkg::STACK_DEPTH-1:0][periph_irq_pkg::PC_W-1:0] stack;
        logic [periph_irq_pkg::SP_W-1:0]                          sp;
        logic [periph_irq_pkg::PC_W-1:0]                          top;
        logic [8:0]                                               phys;
    } state_t;

    state_t st_q;
    state_t st_d;

    // write strobe decode for one register offset
    function automatic logic wr_hit(input logic [periph_irq_pkg::ADDR_W-1:0] a,
                                    input logic                              we,
                                    input logic [periph_irq_pkg::ADDR_W-1:0] ofs);
        wr_hit = we && (a == ofs);
    endfunction

    // bank plus offset to physical address, common window folded onto one bank
    function automatic logic [8:0] map_addr(input logic [1:0] bank,
                                            input logic [6:0] ofs);
        if (ofs >= periph_irq_pkg::COMMON_BASE) begin
            map_addr = {periph_irq_pkg::COMMON_BANK, ofs};
        end else begin
            map_addr = {bank, ofs};
        end
    endfunction

    logic                                match_now;
    logic [periph_irq_pkg::DATA_W-1:0]   set_one;
    logic [periph_irq_pkg::DATA_W-1:0]   set_two;
    logic [periph_irq_pkg::DATA_W-1:0]   pend_one;
    logic [periph_irq_pkg::DATA_W-1:0]   pend_two;
    logic [periph_irq_pkg::SP_W-1:0]     top_idx;

    // timer two equality, flagged only on the first cycle of a match
    assign match_now = (timer_two_count == timer_two_period);

    // next state
    always_comb begin
        st_d = st_q;
        set_one = periph_irq_pkg::RST_REG;
        set_two = periph_irq_pkg::RST_REG;

        // hardware set terms, never gated by enables [RULE_07]
        set_one[periph_irq_pkg::BIT_CONVERSION_DONE] = events.conversion_done; // [RULE_01]
        set_one[periph_irq_pkg::BIT_SERIAL_COLLISION] = events.serial_collision; // [RULE_02]
        set_one[periph_irq_pkg::BIT_SERIAL_PORT] = events.serial_event; // [RULE_03]
        set_one[periph_irq_pkg::BIT_TIMER_TWO_MATCH] = match_now && !st_q.match_prev; // [RULE_04]
        set_one[periph_irq_pkg::BIT_TIMER_ONE_ROLL] = events.timer_one_rollover; // [RULE_05]
        set_two[periph_irq_pkg::BIT_OUTPUT_UNDERVOLT] = events.output_undervolt; // [RULE_09]
        set_two[periph_irq_pkg::BIT_OUTPUT_OVERCURRENT] = events.output_overcurrent; // [RULE_10]
        set_two[periph_irq_pkg::BIT_OUTPUT_OVERVOLT] = events.output_overvolt; // [RULE_11]
        st_d.match_prev = match_now;

        // software writes, then sets win over a simultaneous clear [RULE_13]
        if (wr_hit(reg_addr, reg_we, periph_irq_pkg::OFS_FLAGS_ONE)) begin
            st_d.flags_one = reg_wdata & periph_irq_pkg::MASK_ONE;
        end
        if (wr_hit(reg_addr, reg_we, periph_irq_pkg::OFS_FLAGS_TWO)) begin
            st_d.flags_two = reg_wdata & periph_irq_pkg::MASK_TWO;
        end
        st_d.flags_one = (st_d.flags_one | set_one) & periph_irq_pkg::MASK_ONE; // [RULE_06]
        st_d.flags_two = (st_d.flags_two | set_two) & periph_irq_pkg::MASK_TWO; // [RULE_06]
        // supply status tracks the input level every cycle
        st_d.flags_two[periph_irq_pkg::BIT_INPUT_SUPPLY_LOW] = events.input_supply_low; // [RULE_12]

        // enable and control registers
        if (wr_hit(reg_addr, reg_we, periph_irq_pkg::OFS_ENABLES_ONE)) begin
            st_d.enables_one = reg_wdata & periph_irq_pkg::MASK_ONE;
        end
        if (wr_hit(reg_addr, reg_we, periph_irq_pkg::OFS_ENABLES_TWO)) begin
            st_d.enables_two = reg_wdata & periph_irq_pkg::MASK_TWO;
        end
        if (wr_hit(reg_addr, reg_we, periph_irq_pkg::OFS_INT_CONTROL)) begin
            st_d.int_control = reg_wdata;
        end
        if (wr_hit(reg_addr, reg_we, periph_irq_pkg::OFS_OPTION_CTRL)) begin
            st_d.option_ctrl = reg_wdata;
        end

        // read data, valid only in the cycle after the read strobe
        st_d.rdata = periph_irq_pkg::RST_REG;
        if (reg_re) begin
            case (reg_addr)
                periph_irq_pkg::OFS_FLAGS_ONE:   st_d.rdata = st_q.flags_one; // [RULE_06]
                periph_irq_pkg::OFS_FLAGS_TWO:   st_d.rdata = st_q.flags_two; // [RULE_06]
                periph_irq_pkg::OFS_ENABLES_ONE: st_d.rdata = st_q.enables_one;
                periph_irq_pkg::OFS_ENABLES_TWO: st_d.rdata = st_q.enables_two;
                periph_irq_pkg::OFS_INT_CONTROL: st_d.rdata = st_q.int_control;
                periph_irq_pkg::OFS_OPTION_CTRL: st_d.rdata = st_q.option_ctrl;
                default:                         st_d.rdata = periph_irq_pkg::RST_REG;
            endcase
        end

        // request: per-flag enable, peripheral enable, global enable
        pend_one = st_q.flags_one & st_q.enables_one; // [RULE_18]
        pend_two = st_q.flags_two & st_q.enables_two; // [RULE_18]
        st_d.irq = st_q.int_control[periph_irq_pkg::BIT_GLOBAL_IRQ_ENABLE]
                   && st_q.int_control[periph_irq_pkg::BIT_PERIPH_IRQ_ENABLE] // [RULE_17]
                   && ((|pend_one) || (|pend_two)); // [RULE_19]

        // return stack: only the return address is saved on entry
        if (irq_take) begin
            st_d.stack[st_q.sp] = return_pc; // [RULE_14]
            st_d.sp = st_q.sp + periph_irq_pkg::SP_STEP;
        end else if (return_pop) begin
            st_d.sp = st_q.sp - periph_irq_pkg::SP_STEP;
        end
        top_idx = st_d.sp - periph_irq_pkg::SP_STEP;
        st_d.top = st_d.stack[top_idx];

        // shared window reachable without bank change
        st_d.phys = map_addr(mem_bank, mem_offset); // [RULE_16]
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata     = st_q.rdata;
    assign irq_req       = st_q.irq;
    assign stack_top     = st_q.top;
    assign mem_phys_addr = st_q.phys;

    // ---------------- assertions ----------------

    // a write to flags one, whatever the data
    sequence s_wr_one;
        reg_we && (reg_addr == periph_irq_pkg::OFS_FLAGS_ONE);
    endsequence

    // a read of a flag register
    sequence s_rd_flags;
        reg_re && ((reg_addr == periph_irq_pkg::OFS_FLAGS_ONE)
                   || (reg_addr == periph_irq_pkg::OFS_FLAGS_TWO));
    endsequence

    property p_conv_done;
        @(posedge clk) disable iff (rst)
        events.conversion_done |=> st_q.flags_one[periph_irq_pkg::BIT_CONVERSION_DONE];
    endproperty
    a_conv_done: assert property (p_conv_done) // [RULE_01]
        else $error("conversion done flag not set");

    property p_collision;
        @(posedge clk) disable iff (rst)
        events.serial_collision |=> st_q.flags_one[periph_irq_pkg::BIT_SERIAL_COLLISION];
    endproperty
    a_collision: assert property (p_collision) // [RULE_02]
        else $error("serial collision flag not set");

    property p_serial;
        @(posedge clk) disable iff (rst)
        events.serial_event |=> st_q.flags_one[periph_irq_pkg::BIT_SERIAL_PORT];
    endproperty
    a_serial: assert property (p_serial) // [RULE_03]
        else $error("serial port flag not set");

    property p_t2_match;
        @(posedge clk) disable iff (rst)
        (match_now && !st_q.match_prev) |=> st_q.flags_one[periph_irq_pkg::BIT_TIMER_TWO_MATCH];
    endproperty
    a_t2_match: assert property (p_t2_match) // [RULE_04]
        else $error("timer two match flag not set");

    property p_t2_sticky;
        @(posedge clk) disable iff (rst)
        (st_q.flags_one[periph_irq_pkg::BIT_TIMER_TWO_MATCH] && !reg_we)
        |=> st_q.flags_one[periph_irq_pkg::BIT_TIMER_TWO_MATCH];
    endproperty
    a_t2_sticky: assert property (p_t2_sticky) // [RULE_04]
        else $error("timer two flag dropped without a write");

    property p_t1_roll;
        @(posedge clk) disable iff (rst)
        (events.timer_one_rollover && !st_q.enables_one[periph_irq_pkg::BIT_TIMER_ONE_ROLL])
        |=> st_q.flags_one[periph_irq_pkg::BIT_TIMER_ONE_ROLL];
    endproperty
    a_t1_roll: assert property (p_t1_roll) // [RULE_05]
        else $error("rollover flag not set while disabled");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        s_rd_flags |=> (reg_rdata & ~(($past(reg_addr) == periph_irq_pkg::OFS_FLAGS_ONE)
                                      ? periph_irq_pkg::MASK_ONE : periph_irq_pkg::MASK_TWO))
                       == periph_irq_pkg::RST_REG;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RULE_06]
        else $error("unimplemented flag bits read nonzero");

    property p_set_over_clear;
        @(posedge clk) disable iff (rst)
        (s_wr_one and events.conversion_done)
        |=> st_q.flags_one[periph_irq_pkg::BIT_CONVERSION_DONE];
    endproperty
    a_set_over_clear: assert property (p_set_over_clear) // [RULE_13]
        else $error("event lost against a clearing write");

    property p_faults;
        @(posedge clk) disable iff (rst)
        1'b1
        |=> (st_q.flags_two[periph_irq_pkg::BIT_OUTPUT_UNDERVOLT]
             || !$past(events.output_undervolt))
            && (st_q.flags_two[periph_irq_pkg::BIT_OUTPUT_OVERCURRENT]
                || !$past(events.output_overcurrent))
            && (st_q.flags_two[periph_irq_pkg::BIT_OUTPUT_OVERVOLT]
                || !$past(events.output_overvolt));
    endproperty
    a_faults: assert property (p_faults) // [RULE_09] [RULE_10] [RULE_11]
        else $error("fault flag not set");

    property p_supply;
        @(posedge clk) disable iff (rst)
        1'b1 |=> st_q.flags_two[periph_irq_pkg::BIT_INPUT_SUPPLY_LOW]
                 == $past(events.input_supply_low);
    endproperty
    a_supply: assert property (p_supply) // [RULE_12]
        else $error("supply status does not track input");

    property p_write_read;
        @(posedge clk) disable iff (rst)
        (s_wr_one and (set_one == periph_irq_pkg::RST_REG))
        ##1 (!reg_we && set_one == periph_irq_pkg::RST_REG)
        ##1 (reg_re && reg_addr == periph_irq_pkg::OFS_FLAGS_ONE && set_one == periph_irq_pkg::RST_REG)
        |=> reg_rdata == ($past(reg_wdata, 3) & periph_irq_pkg::MASK_ONE);
    endproperty
    a_write_read: assert property (p_write_read) // [RULE_13]
        else $error("flag write not read back");

    property p_push;
        @(posedge clk) disable iff (rst)
        irq_take |=> (stack_top == $past(return_pc))
                     && (st_q.sp == $past(st_q.sp) + periph_irq_pkg::SP_STEP);
    endproperty
    a_push: assert property (p_push) // [RULE_14]
        else $error("return address not pushed");

    property p_common;
        @(posedge clk) disable iff (rst)
        (mem_offset >= periph_irq_pkg::COMMON_BASE) |=> mem_phys_addr[8:7] == 2'h0;
    endproperty
    a_common: assert property (p_common) // [RULE_16]
        else $error("common window not shared by banks");

    property p_peripheral_irq_enable_gate;
        @(posedge clk) disable iff (rst)
        !st_q.int_control[periph_irq_pkg::BIT_PERIPH_IRQ_ENABLE] |=> !irq_req;
    endproperty
    a_peripheral_irq_enable_gate: assert property (p_peripheral_irq_enable_gate) // [RULE_17]
        else $error("request without peripheral enable");

    property p_request;
        @(posedge clk) disable iff (rst)
        1'b1 |=> irq_req == $past(st_q.int_control[periph_irq_pkg::BIT_GLOBAL_IRQ_ENABLE]
                 && st_q.int_control[periph_irq_pkg::BIT_PERIPH_IRQ_ENABLE]
                 && (|(st_q.flags_one & st_q.enables_one)
                     || |(st_q.flags_two & st_q.enables_two)));
    endproperty
    a_request: assert property (p_request) // [RULE_18] [RULE_19]
        else $error("request does not match enabled flags");

    property p_rdata_idle;
        @(posedge clk) disable iff (rst)
        !reg_re |=> reg_rdata == periph_irq_pkg::RST_REG;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // [RULE_13]
        else $error("read data not cleared");

    property p_banked;
        @(posedge clk) disable iff (rst)
        (mem_offset < periph_irq_pkg::COMMON_BASE)
        |=> mem_phys_addr == {$past(mem_bank), $past(mem_offset)};
    endproperty
    a_banked: assert property (p_banked) // [RULE_16]
        else $error("banked address not mapped");

endmodule

//--- periph_partner.sv
// stand-in for the event-raising peripherals and the processor core
`timescale 1ns/1ps
module periph_partner (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic [7:0]                      fire,
    input  wire logic                            supply_low,
    input  wire logic                            count_run,
    input  wire logic                            take_en,
    input  wire logic                            irq_req,
    output periph_irq_pkg::periph_events_t       events,
    output logic      [7:0]                      timer_two_count,
    output logic                                 irq_take,
    output logic      [periph_irq_pkg::PC_W-1:0] return_pc
);
    logic [7:1] pulse_q;
    logic       seen_q;
    // event strobes follow fire one cycle later; supply status is a plain level
    assign events = {pulse_q, supply_low};
    // strobes, timer count and core entry; return address steps after each entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_q <= 7'h00;
            timer_two_count <= 8'h00;
            irq_take <= 1'b0;
            seen_q <= 1'b0;
            return_pc <= 13'h0123;
        end else begin
            pulse_q <= fire[7:1];
            timer_two_count <= count_run ? timer_two_count + 8'h01 : 8'h00;
            irq_take <= take_en && irq_req && !seen_q; // take once per new request
            seen_q <= irq_req;
            if (irq_take) begin
                return_pc <= return_pc + 13'h0001;
            end
        end
    end
endmodule

//--- peripheral_interrupt_flags_tb.sv
// self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ps
module peripheral_interrupt_flags_tb;
    localparam int LIMIT = 20000;
    logic                                 clk;
    logic                                 rst;
    logic [periph_irq_pkg::ADDR_W-1:0]    reg_addr;
    logic [7:0]                           reg_wdata;
    logic                                 reg_we;
    logic                                 reg_re;
    logic [7:0]                           reg_rdata;
    logic [7:0]                           fire;
    logic                                 supply_low;
    logic                                 count_run;
    logic                                 take_en;
    logic [7:0]                           period;
    logic [1:0]                           mem_bank;
    logic [6:0]                           mem_offset;
    logic [8:0]                           mem_phys_addr;
    periph_irq_pkg::periph_events_t       events;
    logic [7:0]                           t2_count;
    logic                                 irq_take;
    logic                                 irq_req;
    logic [periph_irq_pkg::PC_W-1:0]      return_pc;
    logic [periph_irq_pkg::PC_W-1:0]      stack_top;
    int                                   fails;
    int                                   total_checks;
    int                                   cycles;
    logic [7:0]                           rv;

    peripheral_interrupt_flags dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .events(events), .timer_two_count(t2_count), .timer_two_period(period),
        .irq_take(irq_take), .return_pc(return_pc), .return_pop(1'b0),
        .irq_req(irq_req), .stack_top(stack_top), .mem_bank(mem_bank),
        .mem_offset(mem_offset), .mem_phys_addr(mem_phys_addr));
    periph_partner partner (.clk(clk), .rst(rst), .fire(fire), .supply_low(supply_low),
        .count_run(count_run), .take_en(take_en), .irq_req(irq_req), .events(events),
        .timer_two_count(t2_count), .irq_take(irq_take), .return_pc(return_pc));

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // compare helpers
    task automatic check_reg(input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic check_bit(input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic check_addr(input logic [12:0] exp, input logic [12:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // register port cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic fire_ev(input logic [7:0] v);
        @(posedge clk);
        fire <= v;
        @(posedge clk);
        fire <= 8'h00;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        for (int a = 0; a < 7; a++) begin
            rd(a[3:0], rv);
            check_reg(8'h00, rv);
        end
        $display("test reset done");
    endtask

    task automatic t_bits();
        wr(periph_irq_pkg::OFS_FLAGS_ONE, 8'hFF);
        rd(periph_irq_pkg::OFS_FLAGS_ONE, rv);
        check_reg(8'h73, rv);
        wr(periph_irq_pkg::OFS_FLAGS_TWO, 8'hFF);
        rd(periph_irq_pkg::OFS_FLAGS_TWO, rv);
        check_reg(8'hB0, rv);
        wr(periph_irq_pkg::OFS_FLAGS_ONE, 8'h00);
        wr(periph_irq_pkg::OFS_FLAGS_TWO, 8'h00);
        rd(periph_irq_pkg::OFS_FLAGS_ONE, rv);
        check_reg(8'h00, rv);
        $display("test bits done");
    endtask

    // clearing write in the cycle of an event: the event wins
    task automatic t_collide();
        @(posedge clk);
        fire <= 8'h80;
        wr(periph_irq_pkg::OFS_FLAGS_ONE, 8'h00);
        fire <= 8'h00;
        rd(periph_irq_pkg::OFS_FLAGS_ONE, rv);
        check_reg(8'h40, rv);
        wr(periph_irq_pkg::OFS_FLAGS_ONE, 8'h00);
        $display("test collide done");
    endtask

    // every event strobe alone, all enables off
    task automatic t_events();
        logic [3:0] ofs [1:7];
        logic [7:0] exp [1:7];
        ofs = '{4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
        exp = '{8'h10, 8'h20, 8'h80, 8'h01, 8'h10, 8'h20, 8'h40};
        for (int i = 1; i < 8; i++) begin
            fire_ev(8'h01 << i);
            rd(ofs[i], rv);
            check_reg(exp[i], rv);
            check_bit(1'b0, irq_req);
            rd(ofs[i], rv);
            check_reg(exp[i], rv);
            wr(ofs[i], 8'h00);
        end
        $display("test events done");
    endtask

    task automatic t_timer();
        period <= 8'h05;
        count_run <= 1'b1;
        repeat (20) @(posedge clk);
        count_run <= 1'b0;
        rd(periph_irq_pkg::OFS_FLAGS_ONE, rv);
        check_reg(8'h02, rv);
        rd(periph_irq_pkg::OFS_FLAGS_ONE, rv);
        check_reg(8'h02, rv);
        wr(periph_irq_pkg::OFS_FLAGS_ONE, 8'h00);
        rd(periph_irq_pkg::OFS_FLAGS_ONE, rv);
        check_reg(8'h00, rv);
        $display("test timer done");
    endtask

    task automatic t_supply();
        @(posedge clk);
        supply_low <= 1'b1;
        repeat (2) @(posedge clk);
        rd(periph_irq_pkg::OFS_FLAGS_TWO, rv);
        check_reg(8'h02, rv);
        @(posedge clk);
        supply_low <= 1'b0;
        repeat (2) @(posedge clk);
        rd(periph_irq_pkg::OFS_FLAGS_TWO, rv);
        check_reg(8'h00, rv);
        $display("test supply done");
    endtask

    // request gating and return-address push
    task automatic t_irq();
        wr(periph_irq_pkg::OFS_FLAGS_ONE, 8'h00); // stale flag cleared first
        wr(periph_irq_pkg::OFS_ENABLES_ONE, 8'h40);
        wr(periph_irq_pkg::OFS_INT_CONTROL, 8'h80);
        take_en <= 1'b1;
        fire_ev(8'h80);
        repeat (3) @(posedge clk);
        #1 check_bit(1'b0, irq_req);
        wr(periph_irq_pkg::OFS_INT_CONTROL, 8'hC0);
        for (int k = 0; k < 4 && irq_req !== 1'b1; k++) begin
            @(posedge clk);
        end
        #1 check_bit(1'b1, irq_req);
        repeat (3) @(posedge clk);
        #1 check_addr(13'h0123, stack_top);
        wr(periph_irq_pkg::OFS_ENABLES_ONE, 8'h00);
        repeat (3) @(posedge clk);
        #1 check_bit(1'b0, irq_req);
        $display("test irq done");
    endtask

    task automatic t_mem();
        logic [1:0] bk [3];
        logic [6:0] of [3];
        logic [8:0] ex [3];
        bk = '{2'h2, 2'h3, 2'h1};
        of = '{7'h75, 7'h7F, 7'h20};
        ex = '{9'h075, 9'h07F, 9'h0A0};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            mem_bank <= bk[i];
            mem_offset <= of[i];
            repeat (2) @(posedge clk);
            #1 check_addr({4'h0, ex[i]}, {4'h0, mem_phys_addr});
        end
        $display("test mem done");
    endtask

    initial begin
        {fails, total_checks, cycles} = '0;
        {reg_addr, reg_wdata, reg_we, reg_re, fire} = '0;
        {supply_low, count_run, take_en, mem_bank, mem_offset} = '0;
        period = 8'hFF; // no timer match until the timer test
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_bits();
        t_collide();
        t_events();
        t_timer();
        t_supply();
        t_irq();
        t_mem();
        end_of_test();
    end
endmodule
